// ===== logic/pcc_cfg.svh
// constants for the process channel controller: offsets, fields, codes, timing
`ifndef PCC_CFG_SVH
`define PCC_CFG_SVH

// ------------------------------------------------------------------
// geometry
// ------------------------------------------------------------------
`define PCC_NCH 8
`define PCC_NSRC 8
`define PCC_NRMT 12
`define PCC_LOG_DEPTH 16

// ------------------------------------------------------------------
// register byte offsets, and word indices of the channel registers
// ------------------------------------------------------------------
`define PCC_OFF_STATE 12'h000
`define PCC_OFF_INT_STATUS 12'h004
`define PCC_OFF_INT_CLEAR 12'h008
`define PCC_OFF_INT_ENABLE 12'h00c
`define PCC_OFF_REMOTE 12'h010
`define PCC_OFF_LOG_INDEX 12'h014
`define PCC_OFF_LOG_DATA 12'h018
`define PCC_OFF_LOG_COUNT 12'h01c
`define PCC_OFF_CH_BASE 12'h100
`define PCC_CH_STRIDE 12'h010
`define PCC_CH_CTRL 2'h0
`define PCC_CH_LEVEL 2'h1
`define PCC_CH_DELAY 2'h2

// ------------------------------------------------------------------
// channel control field positions, plus the hysteresis field of the level register
// ------------------------------------------------------------------
`define PCC_F_MODE_LSB 0
`define PCC_F_KIND_LSB 2
`define PCC_F_IDX_LSB 4
`define PCC_F_POL 7
`define PCC_F_FALLBACK 8
`define PCC_F_AUDIO 9
`define PCC_F_HYST_LSB 16

// ------------------------------------------------------------------
// mode and source codes
// ------------------------------------------------------------------
`define PCC_MODE_OFF 2'h0
`define PCC_MODE_ON 2'h1
`define PCC_MODE_AUTO 2'h2
`define PCC_KIND_READING 2'h0
`define PCC_KIND_CLOCK 2'h1
`define PCC_KIND_EMISSION 2'h2
`define PCC_KIND_TTL 2'h3

// ------------------------------------------------------------------
// remote input bit that empties the event log
// ------------------------------------------------------------------
`define PCC_RMT_LOG_CLEAR 8

// ------------------------------------------------------------------
// timing: delay unit is one millisecond
// ------------------------------------------------------------------
`define PCC_CLK_PERIOD_NS 5
`define PCC_TICK_NS 1000000
`define PCC_TICK_CYCLES (`PCC_TICK_NS / `PCC_CLK_PERIOD_NS)

`endif

// ===== logic/pcc_pkg.sv
// types shared by the process channel controller files
package pcc_pkg;

  // apb slave phases, one-hot
  typedef enum logic [1:0] {
    PCC_BUS_IDLE = 2'b01,
    PCC_BUS_ACK = 2'b10
  } pcc_bus_t;

  // per-channel rule and mode
  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] kind;
    logic [2:0] idx;
    logic pol;
    logic fallback;
    logic audio;
    logic [15:0] setpoint;
    logic [15:0] hyst;
    logic [15:0] delay;
  } pcc_chan_cfg_t;

  // everything the rule sources deliver
  typedef struct packed {
    logic [7:0][15:0] level;
    logic [7:0] valid;
    logic [7:0] ion_busy;
    logic [15:0] clock_min;
    logic emission_on;
    logic [7:0] ttl_in;
  } pcc_src_t;

  // what reaches the outside equipment
  typedef struct packed {
    logic [7:0] relay;
    logic [7:0] logic_out_n;
    logic [7:0] lamp;
  } pcc_drive_t;

  // state of one rule evaluator
  typedef struct packed {
    logic st;
    logic [15:0] cnt;
  } pcc_eval_t;

endpackage : pcc_pkg

// ===== logic/pcc_rule_eval.sv
// one channel rule: setpoint compare with hysteresis, fallback and delay
`timescale 1ns/1ps
`include "pcc_cfg.svh"

module pcc_rule_eval
  import pcc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic tick,
  input wire logic cur_state,
  input wire logic [15:0] level,
  input wire logic level_ok,
  input wire logic hold,
  input wire pcc_chan_cfg_t cfg,
  output logic auto_state
);

  pcc_eval_t q;
  pcc_eval_t next_q;
  logic [16:0] lo_th;
  logic [16:0] hi_th;
  logic target;

  // ------------------------------------------------------------------
  // threshold and next state
  // ------------------------------------------------------------------
  always_comb begin
    next_q = q;
    // deactivation point sits hysteresis away on the far side
    lo_th = ({1'b0, cfg.setpoint} > {1'b0, cfg.hyst}) ? ({1'b0, cfg.setpoint} - {1'b0, cfg.hyst}) : 17'h0;
    hi_th = {1'b0, cfg.setpoint} + {1'b0, cfg.hyst};
    if (cfg.pol) begin
      target = q.st ? ({1'b0, level} > lo_th) : (level > cfg.setpoint);
    end else begin
      target = q.st ? ({1'b0, level} < hi_th) : (level < cfg.setpoint);
    end
    if (!run) begin
      // track the channel so entering auto causes no glitch
      next_q.st = cur_state;
      next_q.cnt = 16'h0;
    end else if (!level_ok) begin
      // fail-safe: no reading, take the configured state at once
      next_q.st = cfg.fallback;
      next_q.cnt = 16'h0;
    end else if (hold) begin
      next_q = q; // ion gauge settling or degassing freezes the
    end else if (target == q.st) begin
      next_q.cnt = 16'h0; // condition reverted inside the delay
    end else if (q.cnt >= cfg.delay) begin
      next_q.st = target;
      next_q.cnt = 16'h0;
    end else if (tick) begin
      next_q.cnt = q.cnt + 16'h1;
    end
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign auto_state = q.st;

endmodule : pcc_rule_eval

// ===== logic/pcc_top.sv
// eight-channel process control block with apb registers and event log
// Notes on behaviour
// - eight channels, each relay plus logic output
// - auto source: reading, clock, emission, ttl
// - rule holds source, setpoint, polarity, hysteresis, delay
// - active channel drives logic output low
// - active: relay energized, lamp lit
// - inactive: output high, relay off, lamp dark
// - auto channel active when rule met
// - per-channel mode: off, on, or auto
// - power-up: all manual inactive until commanded
// - gauge off or faulted takes fallback state
// - analog output or overload takes fallback
// - each state change logged with timestamp
// - lamps and per-channel audible alerts signal events
// - twelve remote control inputs provided
// - power loss releases relays, stays off
// - ion gauge settling or degas freezes channel
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "pcc_cfg.svh"

module pcc_top
  import pcc_pkg::*;
#(
  parameter int TICK_CYCLES = `PCC_TICK_CYCLES
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pcc_src_t src,
  input wire logic [11:0] remote_in,
  input wire logic supply_ok,
  input wire logic power_button,
  output pcc_drive_t drive,
  output logic [11:0] remote_func,
  output logic alert,
  output logic irq
);

  typedef struct packed {
    pcc_bus_t bus;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    pcc_chan_cfg_t [7:0] cfg;
    logic [7:0] active;
    logic [7:0] int_status;
    logic [7:0] int_en;
    logic [7:0] pend;
    logic [3:0] log_wp;
    logic [4:0] log_cnt;
    logic [3:0] log_rd;
    logic [17:0] tick_cnt;
    logic tick;
    logic [27:0] ms;
    logic unit_on;
    pcc_drive_t drive;
    logic [11:0] remote;
    logic alert;
    logic irq;
  } pcc_state_t;

  pcc_state_t q;
  pcc_state_t next_q;
  logic [31:0] log_mem [0:`PCC_LOG_DEPTH-1];
  logic log_we;
  logic [31:0] log_wdata;
  logic [7:0] auto_state;
  logic [7:0][15:0] ch_level;
  logic [7:0] ch_ok;
  logic [7:0] ch_hold;

  // ------------------------------------------------------------------
  // per-channel source select and rule evaluator
  // ------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `PCC_NCH; gi++) begin : g_ch
      // source mux: binary sources compare as 0 or 1 against the setpoint
      always_comb begin
        ch_level[gi] = 16'h0;
        ch_ok[gi] = 1'b1;
        ch_hold[gi] = 1'b0;
        case (q.cfg[gi].kind)
          `PCC_KIND_READING: begin
            ch_level[gi] = src.level[q.cfg[gi].idx];
            ch_ok[gi] = src.valid[q.cfg[gi].idx];
            ch_hold[gi] = src.ion_busy[q.cfg[gi].idx];
          end
          `PCC_KIND_CLOCK: ch_level[gi] = src.clock_min;
          `PCC_KIND_EMISSION: ch_level[gi] = {15'h0, src.emission_on};
          `PCC_KIND_TTL: ch_level[gi] = {15'h0, src.ttl_in[q.cfg[gi].idx]};
          default: ch_level[gi] = 16'h0;
        endcase
      end

      pcc_rule_eval u_eval (
        .pclk(pclk),
        .presetn(presetn),
        .run(q.unit_on && (q.cfg[gi].mode == `PCC_MODE_AUTO)),
        .tick(q.tick),
        .cur_state(q.active[gi]),
        .level(ch_level[gi]),
        .level_ok(ch_ok[gi]),
        .hold(ch_hold[gi]),
        .cfg(q.cfg[gi]),
        .auto_state(auto_state[gi])
      );
    end
  endgenerate

  // ------------------------------------------------------------------
  // next state: bus, channels, events, log, outputs
  // ------------------------------------------------------------------
  logic acc;
  logic wr;
  logic ch_hit;
  logic [2:0] ch_sel;
  logic [1:0] ch_reg;
  logic mapped;
  logic [7:0] int_clr;
  logic [7:0] changed;
  logic found;
  logic [31:0] rdata;
  logic log_clr;

  always_comb begin
    next_q = q;
    log_we = 1'b0;
    log_wdata = 32'h0;
    int_clr = 8'h0;
    found = 1'b0;
    log_clr = 1'b0;
    rdata = 32'h0;
    mapped = 1'b1;

    // millisecond tick and timestamp
    next_q.tick = 1'b0;
    if (q.tick_cnt >= 18'(TICK_CYCLES - 1)) begin
      next_q.tick_cnt = 18'h0;
      next_q.tick = 1'b1;
      next_q.ms = q.ms + 28'h1;
    end else begin
      next_q.tick_cnt = q.tick_cnt + 18'h1;
    end

    // apb decode; a write lands only on the completing edge
    acc = psel && penable;
    wr = acc && pwrite && q.pready;
    ch_hit = (paddr[11:7] == `PCC_OFF_CH_BASE >> 7) && (paddr[3:2] != 2'h3);
    ch_sel = paddr[6:4];
    ch_reg = paddr[3:2];

    // read mux
    if (ch_hit) begin
      case (ch_reg)
        `PCC_CH_CTRL: rdata = {22'h0, q.cfg[ch_sel].audio, q.cfg[ch_sel].fallback,
                               q.cfg[ch_sel].pol, q.cfg[ch_sel].idx, q.cfg[ch_sel].kind,
                               q.cfg[ch_sel].mode};
        `PCC_CH_LEVEL: rdata = {q.cfg[ch_sel].hyst, q.cfg[ch_sel].setpoint};
        default: rdata = {16'h0, q.cfg[ch_sel].delay};
      endcase
    end else begin
      case (paddr)
        `PCC_OFF_STATE: rdata = {23'h0, q.unit_on, q.active};
        `PCC_OFF_INT_STATUS: rdata = {24'h0, q.int_status};
        `PCC_OFF_INT_CLEAR: rdata = 32'h0; // write-only
        `PCC_OFF_INT_ENABLE: rdata = {24'h0, q.int_en};
        `PCC_OFF_REMOTE: rdata = {20'h0, q.remote};
        `PCC_OFF_LOG_INDEX: rdata = {28'h0, q.log_rd};
        `PCC_OFF_LOG_DATA: rdata = log_mem[q.log_rd];
        `PCC_OFF_LOG_COUNT: rdata = {27'h0, q.log_cnt};
        default: mapped = 1'b0;
      endcase
    end

    // two-phase answer: pready rises one cycle into the access phase
    case (q.bus)
      PCC_BUS_IDLE: begin
        next_q.pready = 1'b0;
        next_q.pslverr = 1'b0;
        if (acc) begin
          next_q.bus = PCC_BUS_ACK;
          next_q.pready = 1'b1;
          next_q.pslverr = !mapped;
          next_q.prdata = pwrite ? 32'h0 : rdata;
        end
      end
      PCC_BUS_ACK: begin
        next_q.bus = PCC_BUS_IDLE;
        next_q.pready = 1'b0;
        next_q.pslverr = 1'b0;
      end
      default: begin
        next_q.bus = PCC_BUS_IDLE;
        next_q.pready = 1'b0;
      end
    endcase

    // register writes
    if (wr && mapped) begin
      if (ch_hit) begin
        case (ch_reg)
          `PCC_CH_CTRL: begin
            next_q.cfg[ch_sel].mode = pwdata[`PCC_F_MODE_LSB +: 2];
            next_q.cfg[ch_sel].kind = pwdata[`PCC_F_KIND_LSB +: 2];
            next_q.cfg[ch_sel].idx = pwdata[`PCC_F_IDX_LSB +: 3];
            next_q.cfg[ch_sel].pol = pwdata[`PCC_F_POL];
            next_q.cfg[ch_sel].fallback = pwdata[`PCC_F_FALLBACK];
            next_q.cfg[ch_sel].audio = pwdata[`PCC_F_AUDIO];
          end
          `PCC_CH_LEVEL: begin
            next_q.cfg[ch_sel].setpoint = pwdata[15:0];
            next_q.cfg[ch_sel].hyst = pwdata[`PCC_F_HYST_LSB +: 16];
          end
          default: next_q.cfg[ch_sel].delay = pwdata[15:0];
        endcase
      end else begin
        case (paddr)
          `PCC_OFF_INT_CLEAR: int_clr = pwdata[7:0];
          `PCC_OFF_INT_ENABLE: next_q.int_en = pwdata[7:0];
          `PCC_OFF_LOG_INDEX: next_q.log_rd = pwdata[3:0];
          `PCC_OFF_LOG_COUNT: log_clr = 1'b1; // any write empties the log
          default: ;
        endcase
      end
    end

    // supply loss: release everything and wait for the power button
    if (!supply_ok) begin
      next_q.unit_on = 1'b0;
    end else if (power_button) begin
      next_q.unit_on = 1'b1;
    end
    if (!q.unit_on) begin
      // while off every channel sits in manual inactive
      for (int i = 0; i < `PCC_NCH; i++) begin
        next_q.cfg[i].mode = `PCC_MODE_OFF;
      end
    end

    // channel state from mode
    for (int i = 0; i < `PCC_NCH; i++) begin
      case (q.cfg[i].mode)
        `PCC_MODE_ON: next_q.active[i] = 1'b1;
        `PCC_MODE_AUTO: next_q.active[i] = auto_state[i];
        default: next_q.active[i] = 1'b0;
      endcase
      if (!q.unit_on) begin
        next_q.active[i] = 1'b0;
      end
    end
    changed = next_q.active ^ q.active;

    // events: a new change outranks a clear in the same cycle
    next_q.int_status = (q.int_status & ~int_clr) | changed;
    next_q.pend = q.pend | changed;

    // log one pending channel per cycle, lowest first; a burst of
    // eight changes drains in eight cycles, timestamp is the log time
    for (int i = 0; i < `PCC_NCH; i++) begin
      if (q.pend[i] && !found) begin
        found = 1'b1;
        log_we = 1'b1;
        log_wdata = {q.ms, 3'(i), q.active[i]};
        next_q.pend[i] = changed[i];
      end
    end
    if (log_we) begin
      next_q.log_wp = q.log_wp + 4'h1;
      next_q.log_cnt = (q.log_cnt == 5'(`PCC_LOG_DEPTH)) ? q.log_cnt : q.log_cnt + 5'h1;
    end
    if (log_clr || q.remote[`PCC_RMT_LOG_CLEAR]) begin
      next_q.log_wp = 4'h0;
      next_q.log_cnt = 5'h0;
    end

    // outputs, all registered
    next_q.drive.relay = next_q.active;
    next_q.drive.lamp = next_q.active;
    next_q.drive.logic_out_n = ~next_q.active;
    next_q.remote = remote_in;
    next_q.alert = 1'b0;
    for (int i = 0; i < `PCC_NCH; i++) begin
      if (next_q.int_status[i] && q.cfg[i].audio) begin
        next_q.alert = 1'b1;
      end
    end
    next_q.irq = |(next_q.int_status & next_q.int_en);
  end

  // ------------------------------------------------------------------
  // state register; reset is the fail-safe: manual, inactive
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.bus <= PCC_BUS_IDLE;
      q.unit_on <= 1'b1;
      q.drive.logic_out_n <= 8'hff;
    end else begin
      q <= next_q;
    end
  end

  // ------------------------------------------------------------------
  // event log storage; volatile, contents undefined until written
  // ------------------------------------------------------------------
  always_ff @(posedge pclk) begin
    if (log_we) begin
      log_mem[q.log_wp] <= log_wdata;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign drive = q.drive;
  assign remote_func = q.remote;
  assign alert = q.alert;
  assign irq = q.irq;

endmodule : pcc_top

// ===== tb/pcc_equip_model.sv
// far-side equipment model: relay contacts and logic-input sense
`timescale 1ns/1ps

module pcc_equip_model
  import pcc_pkg::*;
(
  input wire pcc_drive_t drive,
  output logic [7:0] no_closed,
  output logic [7:0] nc_closed,
  output logic [7:0] sense_active
);
  // a coil with no drive drops back, so the common pin rests on normally closed
  assign no_closed = drive.relay;
  assign nc_closed = ~drive.relay;
  // the opto input sees a channel as active while its line is pulled low
  assign sense_active = ~drive.logic_out_n;
endmodule : pcc_equip_model

// ===== tb/pcc_top_properties.sv
// concurrent checks on the ports of the channel controller
`timescale 1ns/1ps

module pcc_top_properties
  import pcc_pkg::*;
#(
  parameter int TICK_CYCLES = 4
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic supply_ok,
  input wire logic [11:0] remote_in,
  input wire pcc_drive_t drive,
  input wire logic [11:0] remote_func
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // --------------------------------------------------------------
  // sequences and properties
  // --------------------------------------------------------------
  sequence s_ctrl0_on;
    psel && penable && pready && pwrite && paddr == 12'h100 && pwdata[1:0] == 2'h1 && supply_ok;
  endsequence
  sequence s_relay0_on;
    ##[1:3] drive.relay[0];
  endsequence
  property p_active_low;
    drive.logic_out_n == ~drive.relay;
  endproperty
  property p_lamp;
    drive.lamp == drive.relay;
  endproperty
  property p_powerup;
    $rose(presetn) |-> (drive.relay == 8'h00) [*3];
  endproperty
  property p_power_loss;
    $fell(supply_ok) |-> ##[1:4] (drive.relay == 8'h00);
  endproperty
  property p_manual_on;
    s_ctrl0_on |-> s_relay0_on;
  endproperty
  property p_pready_pulse;
    pready |=> !pready;
  endproperty
  property p_pready_cause;
    pready |-> $past(psel) && $past(penable);
  endproperty
  property p_slverr;
    pslverr |-> pready;
  endproperty
  property p_remote;
    $past(presetn) |-> remote_func == $past(remote_in);
  endproperty

  a_active_low: assert property (p_active_low) else $error("logic output not inverse of relay");
  a_lamp: assert property (p_lamp) else $error("lamp differs from relay");
  a_powerup: assert property (p_powerup) else $error("relay set right after power-up");
  a_power_loss: assert property (p_power_loss) else $error("relay held after supply loss");
  a_manual_on: assert property (p_manual_on) else $error("forced-on channel not energized");
  a_pready_pulse: assert property (p_pready_pulse) else $error("pready longer than one cycle");
  a_pready_cause: assert property (p_pready_cause) else $error("pready without access");
  a_slverr: assert property (p_slverr) else $error("pslverr without pready");
  a_remote: assert property (p_remote) else $error("remote copy wrong");
endmodule : pcc_top_properties

bind pcc_top pcc_top_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .supply_ok(supply_ok), .remote_in(remote_in), .drive(drive), .remote_func(remote_func));

// ===== tb/pcc_top_tb.sv
// self-checking bench for the channel controller over apb
`timescale 1ns/1ps

module pcc_top_tb;
  import pcc_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic supply_ok = 1'b1, power_button = 1'b0, pready, pslverr, alert, irq, serr;
  logic [11:0] paddr = 12'h000, remote_in = 12'h000, remote_func;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0] no_closed, nc_closed, sense_active;
  pcc_src_t src = '0;
  pcc_drive_t drive;
  int error_cnt = 0, samples_checked = 0;

  pcc_top #(.TICK_CYCLES(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src(src), .remote_in(remote_in), .supply_ok(supply_ok), .power_button(power_button), .drive(drive),
    .remote_func(remote_func), .alert(alert), .irq(irq));
  pcc_equip_model equip (.drive(drive), .no_closed(no_closed), .nc_closed(nc_closed),
    .sense_active(sense_active));

  // 200 mhz
  always #2.5 pclk = ~pclk;

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one apb transfer; waits for pready as long as it takes, only the watchdog ends a hang
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // contact state is watched on the equipment side, not on the coil drive
  task automatic wait_on(input logic [7:0] exp);
    int n;
    n = 0;
    while (no_closed !== exp && n < 60) begin
      @(posedge pclk);
      n++;
    end
    chk({24'h0, no_closed}, {24'h0, exp});
  endtask : wait_on

  task automatic hold_chk(input int k, input logic [7:0] exp);
    repeat (k) @(posedge pclk);
    chk({24'h0, no_closed}, {24'h0, exp});
  endtask : hold_chk

  task automatic wrap_up;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  // --------------------------------------------------------------
  // watchdog: the whole sequence needs a few hundred cycles
  // --------------------------------------------------------------
  initial begin
    #100000;
    error_cnt++;
    wrap_up();
  end

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({8'h0, drive}, {8'h0, 8'h00, 8'hff, 8'h00});
    chk({24'h0, nc_closed}, 32'hff);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h100);
    // force every channel on, then off again
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, 12'h100 + 12'(c * 16), 32'h1);
      wait_on(8'h01 << c);
      chk({24'h0, sense_active}, 32'h1 << c);
      apb(1'b1, 12'h100 + 12'(c * 16), 32'h0);
      wait_on(8'h00);
    end
    // auto on reading 1: active above 100, release at 90 or below
    src.valid <= 8'hff;
    src.level[1] <= 16'd50;
    apb(1'b1, 12'h104, 32'h000a0064);
    apb(1'b1, 12'h100, 32'h192);
    hold_chk(5, 8'h00);
    src.level[1] <= 16'd101;
    wait_on(8'h01);
    src.level[1] <= 16'd91;
    hold_chk(10, 8'h01);
    src.level[1] <= 16'd90;
    wait_on(8'h00);
    // two ticks of delay, four cycles each
    apb(1'b1, 12'h108, 32'h2);
    src.level[1] <= 16'd150;
    hold_chk(3, 8'h00);
    wait_on(8'h01);
    src.level[1] <= 16'd50;
    wait_on(8'h00);
    src.ion_busy[1] <= 1'b1;
    src.level[1] <= 16'd150;
    hold_chk(30, 8'h00);
    src.ion_busy[1] <= 1'b0;
    wait_on(8'h01);
    src.level[1] <= 16'd50;
    wait_on(8'h00);
    src.valid[1] <= 1'b0;
    hold_chk(3, 8'h01);
    src.valid[1] <= 1'b1;
    wait_on(8'h00);
    // interrupt enable, mask and clear
    apb(1'b1, 12'h00c, 32'hff);
    hold_chk(2, 8'h00);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'hff);
    chk({31'h0, alert}, 32'h0);
    // audio on channel 2 sounds while its status bit is set
    apb(1'b1, 12'h120, 32'h200);
    @(posedge pclk);
    chk({31'h0, alert}, 32'h1);
    apb(1'b1, 12'h00c, 32'h0);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, 12'h008, 32'hff);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, alert}, 32'h0);
    // event log saturates at sixteen, any write empties it
    apb(1'b0, 12'h01c, 32'h0);
    chk(rd, 32'h10);
    apb(1'b1, 12'h01c, 32'h0);
    apb(1'b0, 12'h01c, 32'h0);
    chk(rd, 32'h0);
    // unmapped slot and remote inputs
    apb(1'b0, 12'h10c, 32'h0);
    chk({serr, rd[30:0]}, 32'h80000000);
    remote_in <= 12'ha5c;
    repeat (2) @(posedge pclk);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd, 32'ha5c);
    // supply loss drops relays; unit stays off until the button
    apb(1'b1, 12'h130, 32'h1);
    wait_on(8'h08);
    supply_ok <= 1'b0;
    wait_on(8'h00);
    supply_ok <= 1'b1;
    hold_chk(10, 8'h00);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    power_button <= 1'b1;
    @(posedge pclk);
    power_button <= 1'b0;
    hold_chk(3, 8'h00);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h100);
    wrap_up();
  end
endmodule : pcc_top_tb
